// File: rtl/rsp_pkg.sv
//======================================================================
// Purpose: Shared constants for the serial port between receiver module and host
// Assumes: 25 MHz clk_in, 8N1 framing, no flow control lines
// Notes:   Baud divisors are rounded to the nearest cycle count
//======================================================================
package rsp_pkg;
	localparam int unsigned CLK_HZ       = 25000000;
	localparam int unsigned DATA_BITS    = 8;
	localparam int unsigned NUM_RATES    = 9;
	localparam logic [3:0]  RATE_DEFAULT = 4'h5;
	// Rate table index 0..8
	localparam int unsigned RATE_BPS [NUM_RATES] = '{9600, 14400, 19200, 38400, 57600,
		115200, 230400, 460800, 1000000};
	localparam int unsigned DIV_W = 12;
	function automatic logic [DIV_W-1:0] rsp_div(input logic [3:0] idx);
		int unsigned r;
		r = (idx < NUM_RATES) ? RATE_BPS[idx] : RATE_BPS[RATE_DEFAULT];
		return DIV_W'((CLK_HZ + r / 2) / r);
	endfunction : rsp_div
	// Sentence enable mask bits
	localparam int unsigned NUM_SENT    = 7;
	localparam logic [6:0]  SENT_RESET  = 7'h3F; // six types, corrections off
	localparam int unsigned SENT_RTCM   = 6;
	localparam int unsigned PERIOD_SEC  = 1;
	localparam int unsigned SEC_CYCLES  = CLK_HZ * PERIOD_SEC;
	// Command bytes from host: upper nibble opcode, lower nibble argument
	localparam logic [3:0]  OP_RATE     = 4'hA;
	localparam logic [3:0]  OP_RTCM_ON  = 4'hB;
	localparam logic [3:0]  OP_RTCM_OFF = 4'hC;
	localparam logic        LINE_IDLE   = 1'b1;
	localparam logic        START_BIT   = 1'b0;
	localparam logic        STOP_BIT    = 1'b1;
endpackage : rsp_pkg

// File: rtl/rsp_uart_fifo.sv
//======================================================================
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   One-cycle write-to-read latency
//======================================================================
`timescale 1ns/1ps
module rsp_uart_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	// Pointer wrap bit only works for power-of-two depths
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("rsp_uart_fifo: bad WIDTH or DEPTH");
	end
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} rsp_fifo_st_t;
	rsp_fifo_st_t st, next_st;
	logic full, empty;
	assign full          = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
	assign empty         = (st.wp == st.rp);
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = st.mem[st.rp[AW-1:0]];
	always_comb begin
		next_st = st;
		if (in_valid_in && !full) begin
			next_st.mem[st.wp[AW-1:0]] = in_data_in;
			next_st.wp = st.wp + 1'b1;
		end
		if (out_ready_in && !empty) begin
			next_st.rp = st.rp + 1'b1;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : rsp_uart_fifo

// File: rtl/rsp_link_if.sv
//======================================================================
// Purpose: Two-wire asynchronous link between module (DCE) and host (DTE)
// Assumes: Straight connection, no handshake lines
// Notes:   Each line has one driver
//======================================================================
`timescale 1ns/1ps
interface rsp_link_if;
	logic host_receive_line;  // device out -> host in
	logic host_transmit_line; // host out -> device in
	modport dce (output host_receive_line, input host_transmit_line);
	modport dte (input host_receive_line, output host_transmit_line);
endinterface : rsp_link_if

// File: rtl/rsp_uart_host.sv
//======================================================================
// Purpose: Host (DTE) end: byte transmit and receive over the link
// Assumes: Rate index from user, must match the device
// Notes:   Received bytes emitted as one-cycle strobes
//======================================================================
`timescale 1ns/1ps
module rsp_uart_host
	import rsp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	rsp_link_if.dte         link,
	input  wire logic [3:0] rate_sel_in,
	input  wire logic       tx_valid_in,
	output logic            tx_ready_out,
	input  wire logic [7:0] tx_data_in,
	output logic            rx_valid_out,
	output logic [7:0]      rx_data_out,
	output logic            rx_frame_err_out
);
	typedef enum {H_IDLE, H_START, H_DATA, H_STOP} rsp_hstate_t;
	typedef struct packed {
		rsp_hstate_t        ts;
		logic [DIV_W-1:0]   tcnt;
		logic [2:0]         tbit;
		logic [7:0]         tsh;
		logic               tline;
		rsp_hstate_t        rs;
		logic [DIV_W-1:0]   rcnt;
		logic [2:0]         rbit;
		logic [7:0]         rsh;
		logic [2:0]         sync;
		logic               filt;
		logic               rv;
		logic [7:0]         rd;
		logic               rerr;
	} rsp_host_st_t;
	rsp_host_st_t st, next_st;
	logic [DIV_W-1:0] div;
	logic             rx_in;
	assign div                    = rsp_div(rate_sel_in);
	// Change only when 2nd and 3rd stages agree
	assign rx_in                  = (st.sync[1] == st.sync[2]) ? st.sync[1] : st.filt;
	assign link.host_transmit_line = st.tline;
	assign tx_ready_out           = (st.ts == H_IDLE);
	assign rx_valid_out           = st.rv;
	assign rx_data_out            = st.rd;
	assign rx_frame_err_out       = st.rerr;
	always_comb begin
		next_st      = st;
		next_st.sync = {st.sync[1:0], link.host_receive_line};
		next_st.filt = rx_in;
		next_st.rv   = 1'b0;
		next_st.rerr = 1'b0;
		// Transmitter
		unique case (st.ts)
			H_IDLE: begin
				next_st.tline = LINE_IDLE;
				if (tx_valid_in) begin
					next_st.tsh   = tx_data_in;
					next_st.tline = START_BIT;
					next_st.tcnt  = div - 1'b1;
					next_st.ts    = H_START;
				end
			end
			H_START, H_DATA, H_STOP: begin
				if (st.tcnt != '0) begin
					next_st.tcnt = st.tcnt - 1'b1;
				end else begin
					next_st.tcnt = div - 1'b1;
					if (st.ts == H_START) begin
						next_st.tline = st.tsh[0];
						next_st.tbit  = '0;
						next_st.ts    = H_DATA;
					end else if (st.ts == H_DATA) begin
						if (st.tbit == 3'(DATA_BITS - 1)) begin
							next_st.tline = STOP_BIT;
							next_st.ts    = H_STOP;
						end else begin
							next_st.tsh   = {1'b0, st.tsh[7:1]};
							next_st.tline = st.tsh[1];
							next_st.tbit  = st.tbit + 1'b1;
						end
					end else begin
						next_st.ts = H_IDLE;
					end
				end
			end
		endcase
		// Receiver samples mid-bit
		unique case (st.rs)
			H_IDLE: begin
				if (rx_in == START_BIT) begin
					next_st.rcnt = {1'b0, div[DIV_W-1:1]};
					next_st.rs   = H_START;
				end
			end
			H_START, H_DATA, H_STOP: begin
				if (st.rcnt != '0) begin
					next_st.rcnt = st.rcnt - 1'b1;
				end else begin
					next_st.rcnt = div - 1'b1;
					if (st.rs == H_START) begin
						next_st.rs   = (rx_in == START_BIT) ? H_DATA : H_IDLE;
						next_st.rbit = '0;
					end else if (st.rs == H_DATA) begin
						next_st.rsh  = {rx_in, st.rsh[7:1]};
						next_st.rbit = st.rbit + 1'b1;
						if (st.rbit == 3'(DATA_BITS - 1)) next_st.rs = H_STOP;
					end else begin
						next_st.rv   = (rx_in == STOP_BIT);
						next_st.rerr = (rx_in != STOP_BIT);
						next_st.rd   = st.rsh;
						next_st.rs   = H_IDLE;
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st       <= '0;
			st.ts    <= H_IDLE;
			st.rs    <= H_IDLE;
			st.tline <= LINE_IDLE;
			st.sync  <= 3'h7;
			st.filt  <= LINE_IDLE;
		end else begin
			st <= next_st;
		end
	end
endmodule : rsp_uart_host

// File: rtl/rsp_uart_dev.sv
//======================================================================
// Purpose: Module (DCE) end: sentence output, command input
// Assumes: Sentence bytes supplied by the user side through a FIFO
// Notes:   Commands: 0xA<n> rate, 0xB0 corrections on, 0xC0 off
//          Rate command acts at once on both directions
//          Sentence text and scheduling stay with the user side
//======================================================================
`timescale 1ns/1ps
module rsp_uart_dev
	import rsp_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = 16,
	parameter int unsigned SEC_CNT    = SEC_CYCLES
) (
	input  wire logic                clk_in,
	input  wire logic                rstn_in,
	rsp_link_if.dce                  link,
	input  wire logic                tx_valid_in,
	output logic                     tx_ready_out,
	input  wire logic [7:0]          tx_data_in,
	output logic                     cmd_valid_out,
	output logic [7:0]               cmd_data_out,
	output logic                     rx_frame_err_out,
	output logic [NUM_SENT-1:0]      sent_enable_out,
	output logic                     sent_tick_out,
	output logic [3:0]               rate_out
);
	//======================================================================
	// Elaboration checks
	if (SEC_CNT < 2) begin : g_bad_sec
		$error("rsp_uart_dev: SEC_CNT too small");
	end
	//======================================================================
	// State
	typedef enum {D_IDLE, D_START, D_DATA, D_STOP} rsp_dstate_t;
	typedef struct packed {
		rsp_dstate_t          ts;
		logic [DIV_W-1:0]     tcnt;
		logic [2:0]           tbit;
		logic [7:0]           tsh;
		logic                 tline;
		rsp_dstate_t          rs;
		logic [DIV_W-1:0]     rcnt;
		logic [2:0]           rbit;
		logic [7:0]           rsh;
		logic [2:0]           sync;
		logic                 filt;
		logic                 cv;
		logic [7:0]           cd;
		logic                 cerr;
		logic [3:0]           rate;
		logic [NUM_SENT-1:0]  sent;
		logic [31:0]          sec;
		logic                 tick;
	} rsp_dev_st_t;
	rsp_dev_st_t st, next_st;
	logic             f_valid, f_ready;
	logic [7:0]       f_data;
	logic [DIV_W-1:0] div;
	logic             rx_in;
	logic             cmd_rate;
	logic             cmd_on;
	logic             cmd_off;
	//======================================================================
	// Sentence FIFO
	// Sentence bytes buffered; back-pressure reaches tx_ready_out
	rsp_uart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.in_data_in    (tx_data_in),
		.out_valid_out (f_valid),
		.out_ready_in  (f_ready),
		.out_data_out  (f_data)
	);
	//======================================================================
	// Line filter, command decode, outputs
	assign div               = rsp_div(st.rate);
	// Glitch filter: change only when 2nd and 3rd stages agree
	// A one-cycle spike on the pin never reaches the receiver
	assign rx_in             = (st.sync[1] == st.sync[2]) ? st.sync[1] : st.filt;
	// Out-of-table rate indices are dropped, never clamped
	assign cmd_rate          = (st.rsh[7:4] == OP_RATE) && (st.rsh[3:0] < 4'(NUM_RATES));
	assign cmd_on            = (st.rsh[7:4] == OP_RTCM_ON);
	assign cmd_off           = (st.rsh[7:4] == OP_RTCM_OFF);
	assign f_ready           = (st.ts == D_IDLE);
	assign link.host_receive_line = st.tline;
	assign cmd_valid_out     = st.cv;
	assign cmd_data_out      = st.cd;
	assign rx_frame_err_out  = st.cerr;
	assign sent_enable_out   = st.sent;
	assign sent_tick_out     = st.tick;
	assign rate_out          = st.rate;
	//======================================================================
	// Next state
	always_comb begin
		next_st      = st;
		next_st.sync = {st.sync[1:0], link.host_transmit_line};
		next_st.filt = rx_in;
		next_st.cv   = 1'b0;
		next_st.cerr = 1'b0;
		next_st.tick = 1'b0;
		//==============================================================
		// Once-per-second sentence slot
		if (st.sec == 32'(SEC_CNT - 1)) begin
			next_st.sec  = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.sec = st.sec + 32'h1;
		end
		//==============================================================
		// Transmitter
		unique case (st.ts)
			D_IDLE: begin
				next_st.tline = LINE_IDLE;
				if (f_valid) begin
					next_st.tsh   = f_data;
					next_st.tline = START_BIT;
					next_st.tcnt  = div - 1'b1;
					next_st.ts    = D_START;
				end
			end
			D_START, D_DATA, D_STOP: begin
				if (st.tcnt != '0) begin
					next_st.tcnt = st.tcnt - 1'b1;
				end else begin
					next_st.tcnt = div - 1'b1;
					if (st.ts == D_START) begin
						next_st.tline = st.tsh[0];
						next_st.tbit  = '0;
						next_st.ts    = D_DATA;
					end else if (st.ts == D_DATA) begin
						if (st.tbit == 3'(DATA_BITS - 1)) begin
							next_st.tline = STOP_BIT;
							next_st.ts    = D_STOP;
						end else begin
							next_st.tsh   = {1'b0, st.tsh[7:1]};
							next_st.tline = st.tsh[1];
							next_st.tbit  = st.tbit + 1'b1;
						end
					end else begin
						next_st.ts = D_IDLE;
					end
				end
			end
		endcase
		//==============================================================
		// Command receiver
		unique case (st.rs)
			D_IDLE: begin
				if (rx_in == START_BIT) begin
					next_st.rcnt = {1'b0, div[DIV_W-1:1]};
					next_st.rs   = D_START;
				end
			end
			D_START, D_DATA, D_STOP: begin
				if (st.rcnt != '0) begin
					next_st.rcnt = st.rcnt - 1'b1;
				end else begin
					next_st.rcnt = div - 1'b1;
					if (st.rs == D_START) begin
						next_st.rs   = (rx_in == START_BIT) ? D_DATA : D_IDLE;
						next_st.rbit = '0;
					end else if (st.rs == D_DATA) begin
						next_st.rsh  = {rx_in, st.rsh[7:1]};
						next_st.rbit = st.rbit + 1'b1;
						if (st.rbit == 3'(DATA_BITS - 1)) next_st.rs = D_STOP;
					end else begin
						next_st.rs   = D_IDLE;
						next_st.cerr = (rx_in != STOP_BIT);
						if (rx_in == STOP_BIT) begin
							next_st.cv = 1'b1;
							next_st.cd = st.rsh;
							// Takes effect at once; a byte in flight takes the new bit time from its next bit
							if (cmd_rate) begin
								next_st.rate = st.rsh[3:0];
							end
							if (cmd_on) begin
								next_st.sent[SENT_RTCM] = 1'b1;
							end
							if (cmd_off) begin
								next_st.sent[SENT_RTCM] = 1'b0;
							end
						end
					end
				end
			end
		endcase
	end
	//======================================================================
	// Registers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st       <= '0;
			st.ts    <= D_IDLE;
			st.rs    <= D_IDLE;
			st.tline <= LINE_IDLE;
			st.sync  <= 3'h7;
			st.filt  <= LINE_IDLE;
			st.rate  <= RATE_DEFAULT;
			st.sent  <= SENT_RESET;
		end else begin
			st <= next_st;
		end
	end
endmodule : rsp_uart_dev

// File: dv/rsp_link_monitor.sv
//======================================================================
// Purpose: Wire checks for the two-line serial link
// Assumes: Bit time between 25 and 2604 cycles of clk_in
// Notes:   Rate may change at run time, so only run lengths are bound
//======================================================================
`timescale 1ns/1ps
module rsp_link_monitor (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic host_receive_line,
	input wire logic host_transmit_line
);
	// Start plus eight zero bits at the slowest rate
	localparam int LOW_MAX = 23436;
	typedef struct packed {
		logic [14:0] rx;
		logic [14:0] tx;
	} rsp_mon_t;
	rsp_mon_t st;
	rsp_mon_t next_st;
	always_comb begin
		next_st.rx = host_receive_line ? 15'h0000 : st.rx + 15'h0001;
		next_st.tx = host_transmit_line ? 15'h0000 : st.tx + 15'h0001;
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	//======================================================================
	// Assertions
	default clocking mon_cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Fastest bit is 25 cycles, so 8 is a safe floor
	sequence s_low8(l); !l [*8]; endsequence
	sequence s_high8(l); l [*8]; endsequence
	idle_rx_a: assert property ($rose(rstn_in) |-> host_receive_line)
		else $error("receive line not idle after reset");
	idle_tx_a: assert property ($rose(rstn_in) |-> host_transmit_line)
		else $error("transmit line not idle after reset");
	start_rx_a: assert property ($fell(host_receive_line) |-> s_low8(host_receive_line))
		else $error("short low run on receive line");
	start_tx_a: assert property ($fell(host_transmit_line) |-> s_low8(host_transmit_line))
		else $error("short low run on transmit line");
	stop_rx_a: assert property ($rose(host_receive_line) |-> s_high8(host_receive_line))
		else $error("short high run on receive line");
	stop_tx_a: assert property ($rose(host_transmit_line) |-> s_high8(host_transmit_line))
		else $error("short high run on transmit line");
	frame_rx_a: assert property (st.rx <= LOW_MAX)
		else $error("receive line low beyond one frame");
	frame_tx_a: assert property (st.tx <= LOW_MAX)
		else $error("transmit line low beyond one frame");
endmodule : rsp_link_monitor

// File: dv/rsp_tb.sv
//======================================================================
// Purpose: Both link ends joined, plus a device end driven by hand
// Assumes: 25 MHz clock, one second shortened to 100 cycles
// Notes:   Bit times 217 at 115200 and 25 at 1000000
//======================================================================
`timescale 1ns/1ps
module testbench;
	logic       clk_in  = 1'b0;
	logic       rstn_in = 1'b0;
	logic [3:0] h_rate  = 4'h5;
	logic       h_tv    = 1'b0;
	logic       d_tv    = 1'b0;
	logic [7:0] h_td    = 8'h00;
	logic [7:0] d_td    = 8'h00;
	logic       h_tr, h_rv, h_fe, d_tr, d_cv, d_fe, d_tick, b_cv, b_fe;
	logic [7:0] h_rd, d_cd, b_cd;
	logic [6:0] d_en;
	logic [3:0] d_rate;
	int         err_total = 0;
	int         checks_done = 0;
	int         cyc = 0;
	int         n_tick = 0;
	int         n_bfe = 0;
	int         n_lfe = 0;
	logic [7:0] cq[$];
	logic [7:0] hq[$];
	logic [7:0] bq[$];
	rsp_link_if link();
	rsp_link_if link_b();
	rsp_uart_dev #(.SEC_CNT(100)) i_rsp_uart_dev (.clk_in(clk_in), .rstn_in(rstn_in),
		.link(link.dce), .tx_valid_in(d_tv), .tx_ready_out(d_tr), .tx_data_in(d_td),
		.cmd_valid_out(d_cv), .cmd_data_out(d_cd), .rx_frame_err_out(d_fe),
		.sent_enable_out(d_en), .sent_tick_out(d_tick), .rate_out(d_rate));
	rsp_uart_host i_rsp_uart_host (.clk_in(clk_in), .rstn_in(rstn_in), .link(link.dte),
		.rate_sel_in(h_rate), .tx_valid_in(h_tv), .tx_ready_out(h_tr), .tx_data_in(h_td),
		.rx_valid_out(h_rv), .rx_data_out(h_rd), .rx_frame_err_out(h_fe));
	// Second device end faces a hand-driven line for broken frames
	rsp_uart_dev #(.SEC_CNT(100)) i_rsp_uart_dev_b (.clk_in(clk_in), .rstn_in(rstn_in),
		.link(link_b.dce), .tx_valid_in(1'b0), .tx_ready_out(), .tx_data_in(8'h00),
		.cmd_valid_out(b_cv), .cmd_data_out(b_cd), .rx_frame_err_out(b_fe),
		.sent_enable_out(), .sent_tick_out(), .rate_out());
	rsp_link_monitor i_rsp_link_monitor (.clk_in(clk_in), .rstn_in(rstn_in),
		.host_receive_line(link.host_receive_line),
		.host_transmit_line(link.host_transmit_line));
	always #20 clk_in = ~clk_in;
	//======================================================================
	// Collectors and helpers
	// Falling edge: outputs launched on the rising edge have settled
	always @(negedge clk_in) begin
		cyc++;
		if (d_cv === 1'b1) cq.push_back(d_cd);
		if (h_rv === 1'b1) hq.push_back(h_rd);
		if (b_cv === 1'b1) bq.push_back(b_cd);
		if (b_fe === 1'b1) n_bfe++;
		if (d_tick === 1'b1) n_tick++;
		if (d_fe === 1'b1 || h_fe === 1'b1) n_lfe++;
		if (cyc == 80000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic do_reset();
		@(negedge clk_in);
		rstn_in = 1'b0;
		repeat (8) @(negedge clk_in);
		rstn_in = 1'b1;
		h_rate = 4'h5;
	endtask : do_reset
	task automatic h_send(input logic [7:0] b);
		int n;
		n = 0;
		while (h_tr !== 1'b1 && n < 30000) begin
			@(negedge clk_in);
			n++;
		end
		chk(n < 30000, 1);
		h_td = b;
		h_tv = 1'b1;
		@(negedge clk_in);
		h_tv = 1'b0;
	endtask : h_send
	task automatic wait_n(input bit rx, input int k);
		int n;
		n = 0;
		while ((rx ? hq.size() : cq.size()) < k && n < 40000) begin
			@(negedge clk_in);
			n++;
		end
		chk(n < 40000, 1);
	endtask : wait_n
	function automatic logic ln(input bit rx);
		return rx ? link.host_receive_line : link.host_transmit_line;
	endfunction : ln
	task automatic chk_wire(input bit rx, input int div, input logic [7:0] b);
		int i;
		do @(negedge clk_in); while (ln(rx) !== 1'b0);
		repeat (div / 2) @(negedge clk_in);
		chk(ln(rx), 0);
		for (i = 0; i < 9; i++) begin
			repeat (div) @(negedge clk_in);
			chk(ln(rx), i < 8 ? b[i] : 1'b1);
		end
	endtask : chk_wire
	task automatic b_bits(input logic [9:0] f);
		int i;
		for (i = 0; i < 10; i++) begin
			link_b.host_transmit_line = f[i];
			repeat (217) @(negedge clk_in);
		end
		link_b.host_transmit_line = 1'b1;
		repeat (2500) @(negedge clk_in);
	endtask : b_bits
	//======================================================================
	// Scenarios
	task automatic t_reset();
		chk(d_rate, 5);
		chk(d_en, 7'h3F);
		chk(d_en[6], 0);
		chk({h_tr, d_tr, link.host_receive_line}, 3'h7);
		n_tick = 0;
		// Window ends mid-period, so no tick sits on its edge
		repeat (1050) @(negedge clk_in);
		chk(n_tick, 10);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_wire();
		cq.delete();
		fork
			h_send(8'h41);
			chk_wire(0, 217, 8'h41);
		join
		h_send(8'h00);
		h_send(8'hFF);
		wait_n(0, 3);
		chk({cq[0], cq[1], cq[2]}, 24'h4100FF);
		$display("t_wire done");
	endtask : t_wire
	task automatic t_rtcm();
		cq.delete();
		h_send(8'hB0);
		wait_n(0, 1);
		chk(d_en, 7'h7F);
		h_send(8'hC3);
		wait_n(0, 2);
		chk(d_en, 7'h3F);
		$display("t_rtcm done");
	endtask : t_rtcm
	task automatic t_bad();
		bq.delete();
		n_bfe = 0;
		link_b.host_transmit_line = 1'b0;
		repeat (50) @(negedge clk_in);
		link_b.host_transmit_line = 1'b1;
		repeat (2500) @(negedge clk_in);
		chk(bq.size(), 0);
		chk(n_bfe, 0);
		b_bits({1'b0, 8'h33, 1'b0});
		chk(bq.size(), 0);
		chk(n_bfe, 1);
		b_bits({1'b1, 8'h5A, 1'b0});
		chk(bq.size(), 1);
		chk(bq[0], 8'h5A);
		chk(n_bfe, 1);
		$display("t_bad done");
	endtask : t_bad
	task automatic t_fifo();
		int n;
		int i;
		cq.delete();
		hq.delete();
		h_send(8'hA8);
		wait_n(0, 1);
		h_rate = 4'h8;
		n = 0;
		fork
			chk_wire(1, 25, 8'h10);
			begin
				while (d_tr === 1'b1 && n < 24) begin
					d_td = 8'h10 + 8'(n);
					d_tv = 1'b1;
					@(negedge clk_in);
					n++;
				end
				d_tv = 1'b0;
				chk(d_tr, 0);
				chk(n, 17);
			end
		join
		wait_n(1, n);
		for (i = 0; i < n; i++) chk(hq[i], 8'h10 + 8'(i));
		chk(d_tr, 1);
		do_reset();
		$display("t_fifo done");
	endtask : t_fifo
	task automatic t_rates();
		int i;
		for (i = 0; i < 10; i++) begin
			cq.delete();
			h_send(8'hA0 + 8'(i));
			wait_n(0, 1);
			chk(d_rate, (i < 9) ? i : 5);
			do_reset();
			chk(d_rate, 5);
		end
		$display("t_rates done");
	endtask : t_rates
	initial begin
		link_b.host_transmit_line = 1'b1;
		do_reset();
		t_reset();
		t_wire();
		t_rtcm();
		t_bad();
		t_fifo();
		t_rates();
		chk(n_lfe, 0);
		end_sim();
	end
endmodule : testbench
